/* dv/uaf_asserts.sv */
module uaf_asserts #(
  parameter NCH = 4,
  parameter AW  = 12
) (
  // clock and reset
  input wire             clk,
  input wire             srst,
  input wire             ce,
  // apb
  input wire             psel,
  input wire             penable,
  input wire [AW-1:0]    paddr,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  // pins and framer side
  input wire [NCH-1:0]   rts_n,
  input wire [NCH-1:0]   dtr_n,
  input wire [NCH-1:0]   serial_out,
  input wire [NCH-1:0]   irq,
  input wire [NCH-1:0]   tx_busy,
  input wire [NCH-1:0]   tx_stop_mid,
  input wire [NCH-1:0]   tx_start_ok,
  input wire [NCH*5-1:0] rx_level,
  input wire [NCH*5-1:0] tx_level,
  input wire             rx_dma_request_n,
  input wire             tx_dma_request_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_PREADY_NEXT: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  AST_PREADY_ONE: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  AST_SLVERR: assert property (pready |-> pslverr == (|paddr[AW-1:7]))
    else $error("pslverr does not match address range");
  AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_RST_OUT: assert property ($past(srst) |-> &rts_n && &dtr_n && &serial_out && irq == 0)
    else $error("outputs not at reset level");
  AST_RX_EMPTY: assert property (rx_level == 0 |=> rx_dma_request_n)
    else $error("rx request low with all queues empty");
  AST_TX_FULL: assert property (tx_level == {NCH{5'h10}} |=> tx_dma_request_n)
    else $error("tx request low with all queues full");
  AST_TX_HOLD: assert property (tx_busy[0] && !tx_stop_mid[0] |=> $stable(tx_start_ok[0]))
    else $error("start permission changed mid byte");
endmodule

bind uaf_top uaf_asserts #(.NCH(NCH), .AW(AW)) u_chk (
  .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rts_n(rts_n), .dtr_n(dtr_n),
  .serial_out(serial_out), .irq(irq), .tx_busy(tx_busy), .tx_stop_mid(tx_stop_mid),
  .tx_start_ok(tx_start_ok), .rx_level(rx_level), .tx_level(tx_level),
  .rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n));

/* dv/uaf_remote.sv */
module uaf_remote (
  // clock
  input wire         clk,
  // handshake
  input wire [3:0]   rts_n,
  input wire         hold,
  output logic [3:0] cts_n = 4'hF
);
  timeunit 1ns;
  timeprecision 1ps;
  // channel 0 is stopped on command; it answers a cycle late, as a slow far end would
  always @(posedge clk) begin
    cts_n[0] <= hold;
    cts_n[3:1] <= rts_n[3:1];
  end
endmodule

/* dv/uart_autoflow_reset_dma_ready_tb_top.sv */
module uart_autoflow_reset_dma_ready_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, hold = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rxq_n, txq_n;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  cts_n, rts_n, dtr_n, serial_out, tx_start_ok, irq, tx_line = 4'h5;
  logic [3:0]  rx_busy = 4'h0, rx_timeout = 4'h0, tx_busy = 4'h0, tx_stop_mid = 4'h0;
  logic [3:0]  rx_buf_read = 4'h0, tx_hold_write = 4'h0;
  logic [19:0] rx_level = 20'h0, tx_level = 20'h0;
  int          mismatches = 0, checks = 0, i;
  logic [11:0] ra [0:6] = '{12'h01C, 12'h07C, 12'h020, 12'h010, 12'h044, 12'h014, 12'h080};
  logic [7:0]  rw [0:6] = '{8'hA5, 8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [31:0] re [0:6] = '{32'hA5, 32'h5A, 32'h0F, 32'h3F, 32'hC9, 32'h60, 32'h00};

  always #2.5 clk = ~clk;

  uaf_top u_dut (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n(cts_n), .dsr_n(4'hF), .ri_n(4'hF), .dcd_n(4'hF), .rts_n(rts_n), .dtr_n(dtr_n),
    .serial_out(serial_out), .tx_line(tx_line), .rx_level(rx_level), .tx_level(tx_level),
    .rx_busy(rx_busy), .rx_timeout(rx_timeout), .rx_err(16'h0), .tx_busy(tx_busy),
    .tx_stop_mid(tx_stop_mid), .rx_buf_read(rx_buf_read), .tx_hold_write(tx_hold_write),
    .tx_start_ok(tx_start_ok), .irq(irq), .rx_dma_request_n(rxq_n), .tx_dma_request_n(txq_n));

  uaf_remote u_far (.clk(clk), .rts_n(rts_n), .hold(hold), .cts_n(cts_n));

  task results;
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; the answer is waited for, never assumed
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rxs(input logic [4:0] l, input logic b);
    rx_level[4:0] <= l;
    rx_busy[0] <= b;
    step(3);
  endtask

  initial begin
    step(12);
    srst <= 1'b0;
    xfer(0, 12'h008, 8'h00);
    chk(rd, 32'h01);
    for (i = 0; i < 7; i++) begin
      xfer(1, ra[i], rw[i]);
      xfer(0, ra[i], 8'h00);
      chk(rd, re[i]);
    end
    xfer(1, 12'h010, 8'h03);
    step(2);
    chk({rts_n[0], dtr_n[0]}, 32'h0);
    srst <= 1'b1;
    step(2);
    chk({rts_n, dtr_n, serial_out, irq}, 32'hFFF0);
    srst <= 1'b0;
    xfer(0, 12'h010, 8'h00);
    chk(rd, 32'h00);
    xfer(0, 12'h00C, 8'h00);
    chk(rd, 32'h00);
    xfer(0, 12'h014, 8'h00);
    chk(rd, 32'h60);
    chk(serial_out, 32'h5);
    xfer(1, 12'h000, 8'h02);
    step(3);
    chk(irq[0], 32'h1);
    tx_hold_write[0] <= 1'b1;
    step(1);
    tx_hold_write[0] <= 1'b0;
    step(3);
    chk(irq[0], 32'h0);
    xfer(1, 12'h000, 8'h08);
    xfer(1, 12'h004, 8'hC1);
    xfer(1, 12'h010, 8'h22);
    step(3);
    chk(rts_n[0], 32'h0);
    rxs(5'h10, 1'b0);
    chk(rts_n[0], 32'h1);
    rx_buf_read[0] <= 1'b1;
    rxs(5'h0F, 1'b1);
    rx_buf_read[0] <= 1'b0;
    chk(rts_n[0], 32'h0);
    rxs(5'h0E, 1'b0);
    rxs(5'h0F, 1'b1);
    chk(rts_n[0], 32'h1);
    rxs(5'h0F, 1'b0);
    chk(rts_n[0], 32'h0);
    // lower triggers hold rts off until the queue drains completely
    xfer(1, 12'h004, 8'h41);
    rxs(5'h04, 1'b0);
    chk(rts_n[0], 32'h1);
    rxs(5'h02, 1'b0);
    chk(rts_n[0], 32'h1);
    rxs(5'h00, 1'b0);
    chk(rts_n[0], 32'h0);
    hold <= 1'b1;
    step(4);
    chk(tx_start_ok[0], 32'h0);
    chk(irq[0], 32'h0);
    hold <= 1'b0;
    step(4);
    chk(tx_start_ok[0], 32'h1);
    tx_busy[0] <= 1'b1;
    step(1);
    hold <= 1'b1;
    step(4);
    chk(tx_start_ok[0], 32'h1);
    tx_stop_mid[0] <= 1'b1;
    step(1);
    tx_stop_mid[0] <= 1'b0;
    step(2);
    chk(tx_start_ok[0], 32'h0);
    tx_busy[0] <= 1'b0;
    xfer(1, 12'h010, 8'h02);
    step(3);
    chk(tx_start_ok[0], 32'h1);
    hold <= 1'b0;
    xfer(1, 12'h004, 8'h01);
    rxs(5'h01, 1'b0);
    chk(rxq_n, 32'h0);
    chk(txq_n, 32'h0);
    tx_level <= {4{5'h03}};
    step(3);
    chk(txq_n, 32'h1);
    // drain first: a request raised in mode 0 stands until the queue empties
    rxs(5'h00, 1'b0);
    xfer(1, 12'h004, 8'h49);
    rxs(5'h01, 1'b0);
    chk(rxq_n, 32'h1);
    rx_timeout[0] <= 1'b1;
    step(1);
    rx_timeout[0] <= 1'b0;
    step(3);
    chk(rxq_n, 32'h0);
    rxs(5'h00, 1'b0);
    chk(rxq_n, 32'h1);
    rxs(5'h04, 1'b0);
    chk(rxq_n, 32'h0);
    tx_level <= {5'h10, 5'h10, 5'h10, 5'h0F};
    step(3);
    chk(txq_n, 32'h0);
    tx_level[4:0] <= 5'h10;
    step(3);
    chk(txq_n, 32'h1);
    results;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    results;
  end
endmodule

/* rtl/uaf_defines.vh */
`ifndef UAF_DEFINES_VH
`define UAF_DEFINES_VH

// byte address = channel * 32 + index * 4
`define UAF_ADDR_CH_LSB      5
`define UAF_ADDR_CH_MSB      6
`define UAF_ADDR_IDX_LSB     2
`define UAF_ADDR_IDX_MSB     4

// register index inside a channel window
`define UAF_IDX_INT_ENABLE   3'h0
`define UAF_IDX_FIFO_CTRL    3'h1
`define UAF_IDX_INT_IDENT    3'h2
`define UAF_IDX_LINE_CTRL    3'h3
`define UAF_IDX_MODEM_CTRL   3'h4
`define UAF_IDX_LINE_STATUS  3'h5
`define UAF_IDX_MODEM_STATUS 3'h6
`define UAF_IDX_SCRATCH      3'h7

// writable bit masks
`define UAF_INT_ENABLE_MASK  8'h0F
`define UAF_FIFO_CTRL_MASK   8'hC9
`define UAF_MODEM_CTRL_MASK  8'h3F
`define UAF_RST_BYTE         8'h00

// field positions
`define UAF_MC_DTR           0
`define UAF_MC_RTS           1
`define UAF_MC_AUTOFLOW      5
`define UAF_FC_ENABLE        0
`define UAF_FC_DMA_MODE      3
`define UAF_FC_TRIG_LSB      6
`define UAF_FC_TRIG_MSB      7
`define UAF_IE_RX_DATA       0
`define UAF_IE_TX_EMPTY      1
`define UAF_IE_LINE          2
`define UAF_IE_MODEM         3
`define UAF_MS_DELTA_CTS     0

// receive trigger selections and levels
`define UAF_TRIG_SEL_1       2'h0
`define UAF_TRIG_SEL_4       2'h1
`define UAF_TRIG_SEL_8       2'h2
`define UAF_TRIG_SEL_14      2'h3
`define UAF_LEVEL_1          5'h01
`define UAF_LEVEL_4          5'h04
`define UAF_LEVEL_8          5'h08
`define UAF_LEVEL_14         5'h0E
`define UAF_LEVEL_LAST       5'h0F
`define UAF_LEVEL_FULL       5'h10
`define UAF_LEVEL_EMPTY      5'h00

// interrupt identification codes, in priority order
`define UAF_ID_LINE          4'h6
`define UAF_ID_RX_DATA       4'h4
`define UAF_ID_TIMEOUT       4'hC
`define UAF_ID_TX_EMPTY      4'h2
`define UAF_ID_MODEM         4'h0
`define UAF_ID_NONE          4'h1

`endif

/* rtl/uaf_top.v */
// How it works
// RQ1 - next byte starts only while cts low
// RQ2 - cts sampled at mid stop bit
// RQ3 - cts delta no interrupt under autoflow
// RQ4 - autoflow when autoflow and rts bits set
// RQ5 - software clears rts bit for cts-only
// RQ6 - trigger level 1/4/8/14 steers auto-rts
// RQ7 - level 14: rts drops on 16th byte
// RQ8 - level 14: rts back when space frees
// RQ9 - without auto-cts transmitter ignores cts
// RQ10 - reset idles channel until programmed; here tx_start_ok rises the cycle after reset
// RQ11 - reset clears status except empty flags
// RQ12 - empty flag pending interrupts once enabled
// RQ13 - reset clears enables, ident reads 01h
// RQ14 - reset clears fifo/modem control; status defaults
// RQ15 - reset drives serial out, rts, dtr high
// RQ16 - interrupt causes cleared by their accesses
// RQ17 - dma mode 0 rx ready when nonempty
// RQ18 - dma mode 1 rx ready at trigger/timeout
// RQ19 - dma mode 0 tx ready when empty
// RQ20 - dma mode 1 tx ready when not full
// RQ21 - four channel readies ANDed together
// RQ22 - 8-bit scratch register, no effect
// RQ23 - level 1/4/8: rts drops, back on empty
// RQ24 - fifo control selects dma mode
`include "uaf_defines.vh"

module uaf_top #(
  parameter NCH = 4,
  parameter AW  = 12
) (
  // clock, reset, enable
  input  wire              clk,
  input  wire              srst,
  input  wire              ce,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [AW-1:0]     paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // modem pins
  input  wire [NCH-1:0]    cts_n,
  input  wire [NCH-1:0]    dsr_n,
  input  wire [NCH-1:0]    ri_n,
  input  wire [NCH-1:0]    dcd_n,
  output reg  [NCH-1:0]    rts_n,
  output reg  [NCH-1:0]    dtr_n,
  output reg  [NCH-1:0]    serial_out,
  // framer and fifo side
  input  wire [NCH-1:0]    tx_line,
  input  wire [NCH*5-1:0]  rx_level,
  input  wire [NCH*5-1:0]  tx_level,
  input  wire [NCH-1:0]    rx_busy,
  input  wire [NCH-1:0]    rx_timeout,
  input  wire [NCH*4-1:0]  rx_err,
  input  wire [NCH-1:0]    tx_busy,
  input  wire [NCH-1:0]    tx_stop_mid,
  input  wire [NCH-1:0]    rx_buf_read,
  input  wire [NCH-1:0]    tx_hold_write,
  output reg  [NCH-1:0]    tx_start_ok,
  output reg  [NCH-1:0]    irq,
  // shared dma requests
  output reg               rx_dma_request_n,
  output reg               tx_dma_request_n
);

  function [4:0] trig_of;
    input [1:0] sel;
    begin
      case (sel)
        `UAF_TRIG_SEL_1:  trig_of = `UAF_LEVEL_1;
        `UAF_TRIG_SEL_4:  trig_of = `UAF_LEVEL_4;
        `UAF_TRIG_SEL_8:  trig_of = `UAF_LEVEL_8;
        default:          trig_of = `UAF_LEVEL_14;
      endcase
    end
  endfunction

  reg  [7:0]       int_enable_reg   [0:NCH-1];
  reg  [7:0]       fifo_control_reg [0:NCH-1];
  reg  [7:0]       line_control_reg [0:NCH-1];
  reg  [7:0]       modem_control_reg[0:NCH-1];
  reg  [7:0]       scratch_byte     [0:NCH-1];
  reg  [3:0]       line_err_r       [0:NCH-1];
  reg  [3:0]       modem_delta_r    [0:NCH-1];
  reg  [3:0]       pins_prev_r      [0:NCH-1];
  reg  [NCH-1:0]   holding_empty_flag;
  reg  [NCH-1:0]   transmitter_empty_flag;
  reg  [NCH-1:0]   tx_empty_prev_r;
  reg  [NCH-1:0]   tx_pend_r;
  reg  [NCH-1:0]   tmo_pend_r;
  reg  [NCH-1:0]   rts_hold_r;
  reg  [NCH-1:0]   was_full_r;
  reg  [NCH-1:0]   rx_req_n_r;
  reg  [31:0]      rd_mux;
  reg              pready_nxt;
  integer          i;

  wire [1:0]       sel_ch  = paddr[`UAF_ADDR_CH_MSB:`UAF_ADDR_CH_LSB];
  wire [2:0]       sel_idx = paddr[`UAF_ADDR_IDX_MSB:`UAF_ADDR_IDX_LSB];
  wire             bad_addr = |paddr[AW-1:`UAF_ADDR_CH_MSB+1];
  wire             acc     = psel & penable & pready;
  wire             wr      = acc & pwrite & ~bad_addr;
  wire             rd      = acc & ~pwrite & ~bad_addr;

  wire [NCH-1:0]   allow_nxt;
  wire [NCH-1:0]   hold_nxt;
  wire [NCH-1:0]   full_nxt;
  wire [NCH-1:0]   rts_n_nxt;
  wire [NCH-1:0]   rxq_n_nxt;
  wire [NCH-1:0]   txq_n_nxt;
  wire [NCH-1:0]   irq_nxt;
  wire [NCH-1:0]   rd_line;
  wire [NCH-1:0]   rd_modem;
  wire [NCH-1:0]   rd_ident;
  wire [NCH*4-1:0] ident;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch_g
      wire [4:0] rxl      = rx_level[g*5 +: 5];
      wire [4:0] txl      = tx_level[g*5 +: 5];
      wire [7:0] mc       = modem_control_reg[g];
      wire [7:0] fc       = fifo_control_reg[g];
      wire [7:0] ie       = int_enable_reg[g];
      wire       auto_cts = mc[`UAF_MC_AUTOFLOW];
      wire       auto_rts = mc[`UAF_MC_AUTOFLOW] & mc[`UAF_MC_RTS];  // RQ4
      wire [1:0] tsel     = fc[`UAF_FC_TRIG_MSB:`UAF_FC_TRIG_LSB];
      wire       at_trig  = rxl >= trig_of(tsel);  // RQ6
      wire       empty    = rxl == `UAF_LEVEL_EMPTY;
      wire       hit      = sel_ch == g;
      wire       stop14;
      wire       ls_int;
      wire       rd_int;
      wire       tm_int;
      wire       tx_int;
      wire       ms_int;
      // the gate only moves between bytes or at mid stop bit, so a late cts
      // release still lets the byte in flight finish
      assign allow_nxt[g] = (~tx_busy[g] | tx_stop_mid[g]) ?
                            (~auto_cts | ~cts_n[g]) : tx_start_ok[g];  // RQ1 RQ2 RQ9
      // from full, the first read lets rts back even with a byte arriving
      assign stop14       = (rxl == `UAF_LEVEL_FULL) |
                            ((rxl == `UAF_LEVEL_LAST) & rx_busy[g] & ~was_full_r[g]);  // RQ7 RQ8
      assign full_nxt[g]  = (rxl == `UAF_LEVEL_FULL) ? 1'b1 :
                            (rxl < `UAF_LEVEL_LAST) ? 1'b0 : was_full_r[g];  // RQ8
      assign hold_nxt[g]  = (tsel == `UAF_TRIG_SEL_14) ? stop14 :
                            at_trig ? 1'b1 : empty ? 1'b0 : rts_hold_r[g];  // RQ23
      assign rts_n_nxt[g] = ~mc[`UAF_MC_RTS] | (auto_rts & hold_nxt[g]);
      assign rxq_n_nxt[g] = empty ? 1'b1 :
                            ~fc[`UAF_FC_DMA_MODE] ? 1'b0 :  // RQ17 RQ24
                            (at_trig | rx_timeout[g]) ? 1'b0 : rx_req_n_r[g];  // RQ18
      assign txq_n_nxt[g] = fc[`UAF_FC_DMA_MODE] ? (txl == `UAF_LEVEL_FULL) :  // RQ20
                            (txl != `UAF_LEVEL_EMPTY);  // RQ19
      assign ls_int  = ie[`UAF_IE_LINE] & |line_err_r[g];
      assign rd_int  = ie[`UAF_IE_RX_DATA] & (fc[`UAF_FC_ENABLE] ? at_trig : ~empty);
      assign tm_int  = ie[`UAF_IE_RX_DATA] & tmo_pend_r[g];
      assign tx_int  = ie[`UAF_IE_TX_EMPTY] & tx_pend_r[g];  // RQ12
      // cts deltas are masked while the transmitter gates itself
      assign ms_int  = ie[`UAF_IE_MODEM] &
                       |(modem_delta_r[g] & {3'h7, ~auto_cts});  // RQ3
      assign ident[g*4 +: 4] = ls_int ? `UAF_ID_LINE :
                               rd_int ? `UAF_ID_RX_DATA :
                               tm_int ? `UAF_ID_TIMEOUT :
                               tx_int ? `UAF_ID_TX_EMPTY :
                               ms_int ? `UAF_ID_MODEM : `UAF_ID_NONE;
      assign irq_nxt[g]  = ident[g*4 +: 4] != `UAF_ID_NONE;
      assign rd_line[g]  = rd & hit & (sel_idx == `UAF_IDX_LINE_STATUS);
      assign rd_modem[g] = rd & hit & (sel_idx == `UAF_IDX_MODEM_STATUS);
      assign rd_ident[g] = rd & hit & (sel_idx == `UAF_IDX_INT_IDENT);
    end
  endgenerate

  // read data is captured in the setup cycle, so clears act on the value shown
  always @* begin
    rd_mux = 32'h0000_0000;
    case (sel_idx)
      `UAF_IDX_INT_ENABLE:   rd_mux[7:0] = int_enable_reg[sel_ch];
      `UAF_IDX_FIFO_CTRL:    rd_mux[7:0] = fifo_control_reg[sel_ch];
      `UAF_IDX_INT_IDENT:    rd_mux[7:0] = {{2{fifo_control_reg[sel_ch][`UAF_FC_ENABLE]}},
                                            2'h0, ident[sel_ch*4 +: 4]};  // RQ13
      `UAF_IDX_LINE_CTRL:    rd_mux[7:0] = line_control_reg[sel_ch];
      `UAF_IDX_MODEM_CTRL:   rd_mux[7:0] = modem_control_reg[sel_ch];
      `UAF_IDX_LINE_STATUS:  rd_mux[7:0] = {1'b0, transmitter_empty_flag[sel_ch],
                                            holding_empty_flag[sel_ch], line_err_r[sel_ch],
                                            rx_level[sel_ch*5 +: 5] != `UAF_LEVEL_EMPTY};
      `UAF_IDX_MODEM_STATUS: rd_mux[7:0] = {~dcd_n[sel_ch], ~ri_n[sel_ch], ~dsr_n[sel_ch],
                                            ~cts_n[sel_ch], modem_delta_r[sel_ch]};  // RQ14
      `UAF_IDX_SCRATCH:      rd_mux[7:0] = scratch_byte[sel_ch];  // RQ22
      default:               rd_mux = 32'h0000_0000;
    endcase
    if (bad_addr) begin
      rd_mux = 32'h0000_0000;
    end
    pready_nxt = psel & ~penable;
  end

  always @(posedge clk) begin
    if (srst) begin
      prdata                 <= 32'h0000_0000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      rts_n                  <= {NCH{1'b1}};  // RQ15
      dtr_n                  <= {NCH{1'b1}};  // RQ15
      serial_out             <= {NCH{1'b1}};  // RQ15
      tx_start_ok            <= {NCH{1'b0}};  // RQ10
      irq                    <= {NCH{1'b0}};  // RQ15
      rx_dma_request_n       <= 1'b1;
      tx_dma_request_n       <= 1'b1;
      holding_empty_flag     <= {NCH{1'b1}};  // RQ11
      transmitter_empty_flag <= {NCH{1'b1}};  // RQ11
      tx_empty_prev_r        <= {NCH{1'b1}};
      tx_pend_r              <= {NCH{1'b1}};  // RQ12
      tmo_pend_r             <= {NCH{1'b0}};
      rts_hold_r             <= {NCH{1'b0}};
      was_full_r             <= {NCH{1'b0}};
      rx_req_n_r             <= {NCH{1'b1}};
      for (i = 0; i < NCH; i = i + 1) begin
        int_enable_reg[i]    <= `UAF_RST_BYTE;  // RQ13
        fifo_control_reg[i]  <= `UAF_RST_BYTE;  // RQ14
        line_control_reg[i]  <= `UAF_RST_BYTE;  // RQ13
        modem_control_reg[i] <= `UAF_RST_BYTE;  // RQ11 RQ14
        scratch_byte[i]      <= `UAF_RST_BYTE;
        line_err_r[i]        <= 4'h0;  // RQ11
        modem_delta_r[i]     <= 4'h0;  // RQ14
        pins_prev_r[i]       <= 4'hF;
      end
    end else if (ce) begin
      pready  <= pready_nxt;
      pslverr <= pready_nxt & bad_addr;
      if (pready_nxt) begin
        prdata <= rd_mux;
      end
      rts_n       <= rts_n_nxt;
      serial_out  <= tx_line;
      tx_start_ok <= allow_nxt;
      irq         <= irq_nxt;
      rts_hold_r  <= hold_nxt;
      was_full_r  <= full_nxt;
      rx_req_n_r  <= rxq_n_nxt;
      rx_dma_request_n <= &rxq_n_nxt;  // RQ21
      tx_dma_request_n <= &txq_n_nxt;  // RQ21
      for (i = 0; i < NCH; i = i + 1) begin
        dtr_n[i] <= ~modem_control_reg[i][`UAF_MC_DTR];
        holding_empty_flag[i]     <= tx_level[i*5 +: 5] == `UAF_LEVEL_EMPTY;
        transmitter_empty_flag[i] <= (tx_level[i*5 +: 5] == `UAF_LEVEL_EMPTY) & ~tx_busy[i];
        tx_empty_prev_r[i]        <= tx_level[i*5 +: 5] == `UAF_LEVEL_EMPTY;
        // every sticky flag: a new event in the clearing cycle wins
        tx_pend_r[i]  <= (tx_pend_r[i] & ~tx_hold_write[i] &
                          ~(rd_ident[i] & (ident[i*4 +: 4] == `UAF_ID_TX_EMPTY))) |
                         ((tx_level[i*5 +: 5] == `UAF_LEVEL_EMPTY) & ~tx_empty_prev_r[i]);  // RQ16
        tmo_pend_r[i] <= (tmo_pend_r[i] & ~rx_buf_read[i]) | rx_timeout[i];  // RQ16
        line_err_r[i] <= (line_err_r[i] & {4{~rd_line[i]}}) | rx_err[i*4 +: 4];  // RQ16
        pins_prev_r[i] <= {dcd_n[i], ri_n[i], dsr_n[i], cts_n[i]};
        modem_delta_r[i] <= (modem_delta_r[i] & {4{~rd_modem[i]}}) |
                            {dcd_n[i] ^ pins_prev_r[i][3], ri_n[i] & ~pins_prev_r[i][2],
                             dsr_n[i] ^ pins_prev_r[i][1], cts_n[i] ^ pins_prev_r[i][0]};  // RQ16
        if (wr && sel_ch == i) begin
          case (sel_idx)
            `UAF_IDX_INT_ENABLE: int_enable_reg[i]    <= pwdata[7:0] & `UAF_INT_ENABLE_MASK;
            `UAF_IDX_FIFO_CTRL:  fifo_control_reg[i]  <= pwdata[7:0] & `UAF_FIFO_CTRL_MASK;
            `UAF_IDX_LINE_CTRL:  line_control_reg[i]  <= pwdata[7:0];
            `UAF_IDX_MODEM_CTRL: modem_control_reg[i] <= pwdata[7:0] & `UAF_MODEM_CTRL_MASK;
            `UAF_IDX_SCRATCH:    scratch_byte[i]      <= pwdata[7:0];  // RQ22
            default:             scratch_byte[i]      <= scratch_byte[i];
          endcase
        end
      end
    end
  end

endmodule
